// ==== hdl/ufl_top.sv ====
// Serial port status flags, interrupt requests, ninth bit, stop and loop logic
// Contract
// RQ1: Three requests: transmit, receive, error groups.
// RQ2: Ten sources each masked; flags stay pollable.
// RQ3: Transmit empty flags buffer room; masked request.
// RQ4: Transmit done only when idle, line high.
// RQ5: Transmit done requests while its enable set.
// RQ6: Receive full clears: status read, data read.
// RQ7: Line quiet clears by same two reads.
// RQ8: Line quiet rearms only after new character.
// RQ9: Error flags set together with receive full.
// RQ10: Overrun discards character, no error flags.
// RQ11: Enabled receiver edge sets flag; write clears.
// RQ12: Nine-bit select gives both directions ninth bit.
// RQ13: Ninth bit copied at shifter load, persists.
// RQ14: Software writes ninth bit before data.
// RQ15: Stop halts clocks; deep stops lose registers.
// RQ16: Edge detector wakes in light stop only.
// RQ17: Software avoids stop during transfers.
// RQ18: Loop mode feeds transmitter to receiver.
// RQ19: Single wire: receiver sees transmitter and pin.
// RQ20: Direction bit picks driving or listening pin.
// RQ21: Single wire receiver hears own characters.
// RQ22: Framing fault blocks new buffer transfers.
// RQ23: Error flags clear by status, data reads.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module ufl_top (
   input wire logic mclk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ufl_pkg::UFL_WB_DW-1:0] wb_dat_i,
   output logic [ufl_pkg::UFL_WB_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Power controller
   input wire logic [1:0] stop_mode,
   output logic wake_o,
   // Transmitter shifter side
   input wire logic tx_take_i,
   input wire logic tx_idle_i,
   input wire logic tx_serial_i,
   output logic [8:0] tx_data_o,
   output logic tx_load_o,
   // Receiver sampler side
   input wire logic rx_char_valid_i,
   input wire logic [8:0] rx_char_i,
   input wire logic rx_noise_i,
   input wire logic rx_frame_i,
   input wire logic rx_parity_i,
   input wire logic rx_idle_i,
   input wire logic rx_break_i,
   output logic rx_serial_o,
   output logic rx_enable_o,
   output logic nine_bit_o,
   // Serial pins
   input wire logic rxd_pin_i,
   input wire logic txd_pin_i,
   output logic txd_pin_o,
   output logic txd_pin_oe,
   output logic rxd_released_o,
   // Interrupt requests
   output logic irq_tx_o,
   output logic irq_rx_o,
   output logic irq_err_o
);
   // Clock gating by stop mode; deep stops act as reset
   logic run_en;
   logic hold_rst;
   logic edge_live;
   assign run_en = (stop_mode == ufl_pkg::UFL_MODE_RUN); // RQ15
   assign hold_rst = reset | stop_mode[1]; // RQ15
   assign edge_live = run_en | (stop_mode == ufl_pkg::UFL_MODE_STOP_LIGHT); // RQ16

   // Control registers
   logic [7:0] ctrl_one_q;
   logic [7:0] ctrl_two_q;
   logic [7:0] ctrl_three_q;
   logic [7:0] edge_ctrl_q;
   // Flags
   logic tx_full_q, tx_done_q, rx_full_q, idle_q, ovr_q, nf_q, fe_q, pf_q;
   logic edge_q, brk_q, idle_allow_q;
   // Status read snapshot for the two-step clear
   logic [5:0] arm_q;
   logic [8:0] tx_buf_q;
   logic [8:0] rx_buf;
   logic rx_prev_q;
   logic ack_q;

   // Decoded access strobes, valid at the acknowledge edge
   logic acc, rd_s1, rd_data, wr_data, wr_s2;
   assign acc = wb_cyc_i & wb_stb_i & ack_q & run_en;
   assign rd_s1 = acc & ~wb_we_i & (wb_adr_i == ufl_pkg::UFL_OFS_STATUS_ONE);
   assign rd_data = acc & ~wb_we_i & (wb_adr_i == ufl_pkg::UFL_OFS_DATA);
   assign wr_data = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == ufl_pkg::UFL_OFS_DATA);
   assign wr_s2 = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == ufl_pkg::UFL_OFS_STATUS_TWO);

   // Receive path events
   logic rx_en, xfer, ovr_ev, edge_ev, clr_full, clr_idle;
   assign rx_en = ctrl_two_q[ufl_pkg::UFL_C2_RX_EN];
   // Framing fault inhibits the buffer, shifter keeps going outside
   assign xfer = rx_char_valid_i & rx_en & run_en & ~fe_q & ~rx_full_q; // RQ22
   assign ovr_ev = rx_char_valid_i & rx_en & run_en & ~fe_q & rx_full_q; // RQ10
   assign clr_full = rd_data & arm_q[5]; // RQ6
   assign clr_idle = rd_data & arm_q[4]; // RQ7

   // Pin routing for normal, loop and single-wire modes
   logic loop_en, src_sel, dir;
   assign loop_en = ctrl_one_q[ufl_pkg::UFL_C1_LOOP];
   assign src_sel = ctrl_one_q[ufl_pkg::UFL_C1_SRC];
   assign dir = ctrl_three_q[ufl_pkg::UFL_C3_DIR];
   always_comb begin
      rx_serial_o = rxd_pin_i;
      txd_pin_o = tx_serial_i;
      txd_pin_oe = 1'b1;
      rxd_released_o = 1'b0;
      if (loop_en && !src_sel) begin
         // Loop: receiver hears transmitter only
         rx_serial_o = tx_serial_i; // RQ18
         rxd_released_o = 1'b1; // RQ18
      end else if (loop_en) begin
         // Single wire: own output looped back while driving
         txd_pin_oe = dir; // RQ20
         rx_serial_o = dir ? tx_serial_i : txd_pin_i; // RQ19 RQ21
         rxd_released_o = 1'b1; // RQ19
      end
   end

   // Falling edge on the selected receive input; idle line is high
   assign edge_ev = rx_prev_q & ~rx_serial_o & rx_en & edge_live; // RQ11 RQ16

   // Acknowledge straight from its register
   assign wb_ack_o = ack_q;

   // Bus acknowledge: one wait cycle, dropped after one cycle
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q & run_en;
      end
   end

   // Register read multiplexer; unmapped offsets read zero
   function automatic logic [7:0] read_reg(input logic [4:0] adr);
      logic [7:0] v;
      v = 8'h00;
      case (adr)
         ufl_pkg::UFL_OFS_STATUS_ONE: v = {~tx_full_q, tx_done_q, rx_full_q, idle_q,
                                           ovr_q, nf_q, fe_q, pf_q};
         ufl_pkg::UFL_OFS_CONTROL_ONE: v = ctrl_one_q;
         ufl_pkg::UFL_OFS_CONTROL_TWO: v = ctrl_two_q;
         ufl_pkg::UFL_OFS_CONTROL_THREE: v = {rx_buf[8], ctrl_three_q[6:0]}; // RQ12
         ufl_pkg::UFL_OFS_DATA: v = rx_buf[7:0];
         ufl_pkg::UFL_OFS_STATUS_TWO: v = {brk_q, edge_q, 6'h00};
         ufl_pkg::UFL_OFS_EDGE_CTRL: v = edge_ctrl_q;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   // Read data captured with the acknowledge
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q && run_en) begin
         wb_dat_o <= {24'h000000, read_reg(wb_adr_i)};
      end
   end

   // Software control registers; frozen in light stop, cleared in deep stops
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         ctrl_one_q <= ufl_pkg::UFL_RST_CTRL;
         ctrl_two_q <= ufl_pkg::UFL_RST_CTRL;
         ctrl_three_q <= ufl_pkg::UFL_RST_CTRL;
         edge_ctrl_q <= ufl_pkg::UFL_RST_CTRL;
      end else if (acc && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            ufl_pkg::UFL_OFS_CONTROL_ONE: ctrl_one_q <= wb_dat_i[7:0];
            ufl_pkg::UFL_OFS_CONTROL_TWO: ctrl_two_q <= wb_dat_i[7:0];
            // Received ninth bit position is read-only
            ufl_pkg::UFL_OFS_CONTROL_THREE: ctrl_three_q <= {1'b0, wb_dat_i[6:0]};
            ufl_pkg::UFL_OFS_EDGE_CTRL: edge_ctrl_q <= {wb_dat_i[7:6], 6'h00};
            default: ctrl_one_q <= ctrl_one_q;
         endcase
      end
   end

   // Transmit buffer; a write during a take still lands in the buffer
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         tx_full_q <= 1'b0;
         tx_buf_q <= ufl_pkg::UFL_RST_DATA;
      end else if (run_en) begin
         if (wr_data) begin
            tx_buf_q <= {1'b0, wb_dat_i[7:0]};
            tx_full_q <= 1'b1; // RQ3
         end else if (tx_take_i && tx_full_q) begin
            tx_full_q <= 1'b0; // RQ3
         end
      end
   end

   // Shifter load: ninth bit sampled from the persistent control bit
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         tx_data_o <= ufl_pkg::UFL_RST_DATA;
         tx_load_o <= 1'b0;
      end else if (run_en) begin
         tx_load_o <= tx_take_i & tx_full_q;
         if (tx_take_i && tx_full_q) begin
            tx_data_o <= {ctrl_three_q[ufl_pkg::UFL_C3_TX_NINTH] & nine_bit_o,
                          tx_buf_q[7:0]}; // RQ13 RQ12
         end
      end else begin
         tx_load_o <= 1'b0;
      end
   end

   // Transmit done follows the idle, empty, high-line condition
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         tx_done_q <= 1'b0;
      end else if (run_en) begin
         tx_done_q <= tx_idle_i & ~tx_full_q & ~wr_data & tx_serial_i; // RQ4
      end
   end

   // Snapshot of set flags at a status read, consumed by a data read
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         arm_q <= 6'h00;
      end else if (rd_s1) begin
         arm_q <= {rx_full_q, idle_q, ovr_q, nf_q, fe_q, pf_q};
      end else if (rd_data) begin
         arm_q <= 6'h00;
      end
   end

   // Receive full flag; a character arriving with the clear counts as overrun, the clear wins
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         rx_full_q <= 1'b0;
      end else if (run_en) begin
         rx_full_q <= xfer | (rx_full_q & ~clr_full); // RQ6
      end
   end

   // Noise, framing and parity flags latch with the character that sets receive full; overrun latches with a dropped character
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         nf_q <= 1'b0;
         fe_q <= 1'b0;
         pf_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (run_en) begin
         nf_q <= (xfer & rx_noise_i) | (nf_q & ~(rd_data & arm_q[2])); // RQ9 RQ23
         fe_q <= (xfer & rx_frame_i) | (fe_q & ~(rd_data & arm_q[1])); // RQ9 RQ23
         pf_q <= (xfer & rx_parity_i) | (pf_q & ~(rd_data & arm_q[0])); // RQ9 RQ23
         ovr_q <= ovr_ev | (ovr_q & ~(rd_data & arm_q[3])); // RQ10 RQ23
      end
   end

   // Line quiet flag with rearm after a received character
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         idle_q <= 1'b0;
         idle_allow_q <= 1'b1;
      end else if (run_en) begin
         idle_q <= (rx_idle_i & rx_en & idle_allow_q) | (idle_q & ~clr_idle); // RQ7 RQ8
         if (xfer) begin
            idle_allow_q <= 1'b1; // RQ8
         end else if (rx_idle_i && rx_en && idle_allow_q) begin
            idle_allow_q <= 1'b0; // RQ8
         end
      end
   end

   // Receive buffer holds the character and its ninth bit
   ufl_char_buf #(
      .WIDTH(9)
   ) u_rx_buf (
      .mclk(mclk),
      .clr(hold_rst),
      .load(xfer),
      .din({rx_char_i[8] & nine_bit_o, rx_char_i[7:0]}), // RQ12
      .dout(rx_buf)
   );

   // Edge detector runs in light stop too
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         rx_prev_q <= 1'b1;
         edge_q <= 1'b0;
      end else if (edge_live) begin
         rx_prev_q <= rx_serial_o;
         edge_q <= edge_ev | (edge_q & ~(wr_s2 & wb_dat_i[ufl_pkg::UFL_S2_EDGE])); // RQ11
      end
   end

   // Break detect flag, write one to clear, set wins
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         brk_q <= 1'b0;
      end else if (run_en) begin
         brk_q <= (rx_break_i & rx_en) | (brk_q & ~(wr_s2 & wb_dat_i[ufl_pkg::UFL_S2_BREAK]));
      end
   end

   // Masked request groups; flags poll regardless of masks
   assign irq_tx_o = (~tx_full_q & ctrl_two_q[ufl_pkg::UFL_C2_TX_EMPTY_IE]) // RQ1 RQ3
                   | (tx_done_q & ctrl_two_q[ufl_pkg::UFL_C2_TX_DONE_IE]); // RQ5
   assign irq_rx_o = (rx_full_q & ctrl_two_q[ufl_pkg::UFL_C2_RX_FULL_IE]) // RQ1 RQ2
                   | (idle_q & ctrl_two_q[ufl_pkg::UFL_C2_IDLE_IE])
                   | (edge_q & edge_ctrl_q[ufl_pkg::UFL_S2_EDGE])
                   | (brk_q & edge_ctrl_q[ufl_pkg::UFL_S2_BREAK]);
   assign irq_err_o = |({ovr_q, nf_q, fe_q, pf_q} & ctrl_three_q[3:0]); // RQ1 RQ2
   // Wake only from light stop on an enabled edge
   assign wake_o = (stop_mode == ufl_pkg::UFL_MODE_STOP_LIGHT) & edge_q
                 & edge_ctrl_q[ufl_pkg::UFL_S2_EDGE]; // RQ16
   assign rx_enable_o = rx_en;
   assign nine_bit_o = ctrl_one_q[ufl_pkg::UFL_C1_NINE]; // RQ12

   // Checks on the flag and routing behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_data_read;
      rd_data && !xfer;
   endsequence

   // Helper: a status read saw receive full; any gap length until the data read
   logic chk_full_seen_q;
   always_ff @(posedge mclk) begin
      if (hold_rst) begin
         chk_full_seen_q <= 1'b0;
      end else if (rd_s1) begin
         chk_full_seen_q <= rx_full_q;
      end else if (rd_data) begin
         chk_full_seen_q <= 1'b0;
      end
   end

   chk_full_two_step: assert property ( // RQ6
      chk_full_seen_q ##0 s_data_read |=> !rx_full_q)
      else $error("receive full not cleared by status then data read");
   chk_tx_empty_irq: assert property ( // RQ3
      !tx_full_q && ctrl_two_q[ufl_pkg::UFL_C2_TX_EMPTY_IE] |-> irq_tx_o)
      else $error("transmit empty request missing");
   chk_err_masked: assert property ( // RQ2
      ctrl_three_q[3:0] == 4'h0 |-> !irq_err_o)
      else $error("error request while all masks clear");
   chk_err_with_full: assert property ( // RQ9
      $rose(nf_q) || $rose(pf_q) |-> $rose(rx_full_q))
      else $error("error flag set without receive full");
   chk_overrun_drop: assert property ( // RQ10
      ovr_ev && !clr_full |=> ovr_q && $stable(rx_buf) && $stable(nf_q))
      else $error("overrun did not discard character");
   chk_idle_rearm: assert property ( // RQ8
      $fell(idle_q) |-> !idle_allow_q ##1 (!idle_q throughout (!xfer)[*3]))
      else $error("line quiet set again without new character");
   chk_edge_flag: assert property ( // RQ11
      edge_ev |=> edge_q)
      else $error("receive edge flag not set");
   chk_ninth_copy: assert property ( // RQ13
      run_en && tx_take_i && tx_full_q && nine_bit_o
      |=> tx_load_o && tx_data_o[8] == $past(ctrl_three_q[ufl_pkg::UFL_C3_TX_NINTH]))
      else $error("ninth bit not copied at shifter load");
   chk_fe_block: assert property ( // RQ22
      fe_q && rx_char_valid_i && !rd_data |=> !$rose(rx_full_q))
      else $error("character transferred under framing fault");
   chk_loop_route: assert property ( // RQ18
      loop_en && !src_sel |-> rx_serial_o == tx_serial_i && rxd_released_o && txd_pin_oe)
      else $error("loop mode routing wrong");
   chk_one_wire_dir: assert property ( // RQ20
      loop_en && src_sel |-> txd_pin_oe == dir && (dir || rx_serial_o == txd_pin_i))
      else $error("single wire direction wrong");
   chk_light_hold: assert property ( // RQ15
      stop_mode == ufl_pkg::UFL_MODE_STOP_LIGHT |=> $stable(ctrl_two_q) && $stable(rx_full_q))
      else $error("registers changed in light stop");
   chk_tx_done_cond: assert property ( // RQ4
      tx_done_q |-> $past(tx_idle_i) && $past(tx_serial_i))
      else $error("transmit done while not idle");
endmodule : ufl_top

// ==== hdl/ufl_pkg.sv ====
// Shared constants for the serial port flag, ninth bit and loop logic
package ufl_pkg;
   // Register byte offsets
   localparam logic [4:0] UFL_OFS_STATUS_ONE = 5'h00;
   localparam logic [4:0] UFL_OFS_CONTROL_ONE = 5'h04;
   localparam logic [4:0] UFL_OFS_CONTROL_TWO = 5'h08;
   localparam logic [4:0] UFL_OFS_CONTROL_THREE = 5'h0C;
   localparam logic [4:0] UFL_OFS_DATA = 5'h10;
   localparam logic [4:0] UFL_OFS_STATUS_TWO = 5'h14;
   localparam logic [4:0] UFL_OFS_EDGE_CTRL = 5'h18;
   // Status one bit positions
   localparam int UFL_S1_TX_EMPTY = 7;
   localparam int UFL_S1_TX_DONE = 6;
   localparam int UFL_S1_RX_FULL = 5;
   localparam int UFL_S1_IDLE = 4;
   localparam int UFL_S1_OVERRUN = 3;
   localparam int UFL_S1_NOISE = 2;
   localparam int UFL_S1_FRAMING = 1;
   localparam int UFL_S1_PARITY = 0;
   // Control one bit positions
   localparam int UFL_C1_LOOP = 7;
   localparam int UFL_C1_SRC = 5;
   localparam int UFL_C1_NINE = 4;
   // Control two bit positions
   localparam int UFL_C2_TX_EMPTY_IE = 7;
   localparam int UFL_C2_TX_DONE_IE = 6;
   localparam int UFL_C2_RX_FULL_IE = 5;
   localparam int UFL_C2_IDLE_IE = 4;
   localparam int UFL_C2_RX_EN = 2;
   // Control three bit positions; low four are error enables
   localparam int UFL_C3_RX_NINTH = 7;
   localparam int UFL_C3_TX_NINTH = 6;
   localparam int UFL_C3_DIR = 5;
   localparam int UFL_C3_OR_IE = 3;
   localparam int UFL_C3_NF_IE = 2;
   localparam int UFL_C3_FE_IE = 1;
   localparam int UFL_C3_PF_IE = 0;
   // Status two and edge control bit positions
   localparam int UFL_S2_BREAK = 7;
   localparam int UFL_S2_EDGE = 6;
   // Reset values
   localparam logic [7:0] UFL_RST_CTRL = 8'h00;
   localparam logic [8:0] UFL_RST_DATA = 9'h000;
   // Stop mode codes on the power controller input
   localparam logic [1:0] UFL_MODE_RUN = 2'h0;
   localparam logic [1:0] UFL_MODE_STOP_LIGHT = 2'h1;
   // Bus data width
   localparam int UFL_WB_DW = 32;
endpackage : ufl_pkg

// ==== hdl/ufl_char_buf.sv ====
// Receive character buffer with registered read data
`timescale 1ns/100ps
module ufl_char_buf #(
   parameter int WIDTH = 9
) (
   input wire logic mclk,
   input wire logic clr, // Synchronous clear, wins over load
   input wire logic load, // Capture a new character
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // Holding register, read straight from the flops
   always_ff @(posedge mclk) begin
      if (clr) begin
         dout <= WIDTH'(ufl_pkg::UFL_RST_DATA);
      end else if (load) begin
         dout <= din;
      end
   end
endmodule : ufl_char_buf

// ==== test/ufl_line_model.sv ====
// Far end of the shared serial wire: a remote transceiver plus the line pull-up
`timescale 1ns/100ps
module ufl_line_model (
   input wire logic txd_pin_o, // Level from the block
   input wire logic txd_pin_oe, // High while the block drives the wire
   input wire logic far_en, // Remote end drives the wire
   input wire logic far_lvl, // Level the remote end sends
   output logic line // Resolved wire level
);
   // Wire resolution; the pull-up keeps an undriven line at mark level
   // Contention is not modelled: the bench only talks while the block listens
   always_comb begin
      if (txd_pin_oe) begin
         line = txd_pin_o;
      end else if (far_en) begin
         line = far_lvl;
      end else begin
         line = 1'b1;
      end
   end
endmodule : ufl_line_model

// ==== test/tb.sv ====
// Self-checking bench for the flag, ninth bit, stop and loop logic
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
   logic mclk, reset, wb_cyc, wb_stb, wb_we, wb_ack, stop_lo, wake;
   logic [4:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat;
   logic [1:0] stop_mode;
   logic tx_take, tx_idle, tx_ser, tx_load, rx_valid, rx_nf, rx_fe, rx_pf, rx_idle, rx_brk;
   logic [8:0] tx_data, rx_char;
   logic rx_ser, rx_en, nine, rxd, txd_o, txd_oe, rxd_rel, far_en, far_lvl, wire_lvl;
   logic irq_tx, irq_rx, irq_err;
   logic [7:0] q;
   int bad_count = 0;
   int n_tests = 0;
   // Device under test
   ufl_top ufl_top_inst (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .stop_mode(stop_mode), .wake_o(wake),
      .tx_take_i(tx_take), .tx_idle_i(tx_idle), .tx_serial_i(tx_ser), .tx_data_o(tx_data),
      .tx_load_o(tx_load), .rx_char_valid_i(rx_valid), .rx_char_i(rx_char),
      .rx_noise_i(rx_nf), .rx_frame_i(rx_fe), .rx_parity_i(rx_pf), .rx_idle_i(rx_idle),
      .rx_break_i(rx_brk), .rx_serial_o(rx_ser), .rx_enable_o(rx_en), .nine_bit_o(nine),
      .rxd_pin_i(rxd), .txd_pin_i(wire_lvl), .txd_pin_o(txd_o), .txd_pin_oe(txd_oe),
      .rxd_released_o(rxd_rel), .irq_tx_o(irq_tx), .irq_rx_o(irq_rx), .irq_err_o(irq_err));
   // Remote end of the shared wire
   ufl_line_model ufl_line_model_inst (.txd_pin_o(txd_o), .txd_pin_oe(txd_oe),
      .far_en(far_en), .far_lvl(far_lvl), .line(wire_lvl));
   // Clock, 4 ns period
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Verdict and end of run
   task end_sim;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // Classic single Wishbone cycle; waits for ack under a bound
   task automatic acc(input logic we, input logic [4:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= {24'h000000, d};
      do begin
         @(posedge mclk);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      q = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      if (k >= 50) begin
         bad_count++;
         end_sim;
      end
   endtask : acc
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   // Read and compare one register
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask : rd
   // Let a few edges pass, then sample settled outputs
   task automatic idle_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : idle_cyc
   // One completed character from the sampler
   task automatic rx_put(input logic [8:0] c, input logic n, input logic f, input logic p);
      @(posedge mclk);
      {rx_valid, rx_char, rx_nf, rx_fe, rx_pf} <= {1'b1, c, n, f, p};
      @(posedge mclk);
      rx_valid <= 1'b0;
      idle_cyc(1);
   endtask : rx_put
   // Shifter asks for a character; load pulse seen one cycle later
   task automatic take(input logic [8:0] e);
      @(posedge mclk);
      tx_take <= 1'b1;
      @(posedge mclk);
      tx_take <= 1'b0;
      #1;
      `CHK(tx_load, 1'b1)
      `CHK(tx_data, e)
   endtask : take
   // Falling edge on the selected receive input
   task automatic fall;
      @(posedge mclk);
      rxd <= 1'b1;
      idle_cyc(2);
      rxd <= 1'b0;
      idle_cyc(3);
   endtask : fall
   task automatic t_reset;
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      rd(5'h1C, 8'h00);
      `CHK({irq_tx, irq_rx, irq_err}, 3'h0)
      $display("test reset done");
   endtask : t_reset
   task automatic t_rx;
      wr(ufl_pkg::UFL_OFS_CONTROL_ONE, 8'h10);
      wr(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h24);
      wr(ufl_pkg::UFL_OFS_CONTROL_THREE, 8'h04);
      rx_put(9'h1A5, 1'b1, 1'b0, 1'b0);
      `CHK({irq_tx, irq_rx, irq_err}, 3'h3)
      `CHK({rx_en, nine}, 2'h3)
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'hA4);
      rx_put(9'h033, 1'b0, 1'b0, 1'b1);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'hAC);
      rd(ufl_pkg::UFL_OFS_CONTROL_THREE, 8'h84);
      rd(ufl_pkg::UFL_OFS_DATA, 8'hA5);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      `CHK({irq_rx, irq_err}, 2'h0)
      rx_idle <= 1'b1;
      idle_cyc(1);
      rx_idle <= 1'b0;
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h90);
      rd(ufl_pkg::UFL_OFS_DATA, 8'hA5);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      rx_idle <= 1'b1;
      idle_cyc(1);
      rx_idle <= 1'b0;
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      rx_put(9'h011, 1'b0, 1'b1, 1'b0);
      rx_put(9'h022, 1'b0, 1'b0, 1'b0);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'hA2);
      rd(ufl_pkg::UFL_OFS_DATA, 8'h11);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      $display("test receive done");
   endtask : t_rx
   task automatic t_tx;
      wr(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h80);
      #1;
      `CHK(irq_tx, 1'b1)
      wr(ufl_pkg::UFL_OFS_CONTROL_THREE, 8'h40);
      wr(ufl_pkg::UFL_OFS_DATA, 8'h5A);
      #1;
      `CHK(irq_tx, 1'b0)
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h00);
      take(9'h15A);
      wr(ufl_pkg::UFL_OFS_DATA, 8'h33);
      take(9'h133);
      tx_idle <= 1'b1;
      idle_cyc(3);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'hC0);
      wr(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h40);
      #1;
      `CHK(irq_tx, 1'b1)
      tx_ser <= 1'b0;
      idle_cyc(3);
      rd(ufl_pkg::UFL_OFS_STATUS_ONE, 8'h80);
      tx_ser <= 1'b1;
      tx_idle <= 1'b0;
      $display("test transmit done");
   endtask : t_tx
   task automatic t_edge;
      wr(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h04);
      fall;
      rx_brk <= 1'b1;
      idle_cyc(1);
      rx_brk <= 1'b0;
      rd(ufl_pkg::UFL_OFS_STATUS_TWO, 8'hC0);
      wr(ufl_pkg::UFL_OFS_STATUS_TWO, 8'hC0);
      rd(ufl_pkg::UFL_OFS_STATUS_TWO, 8'h00);
      wr(ufl_pkg::UFL_OFS_EDGE_CTRL, 8'h40);
      stop_mode <= ufl_pkg::UFL_MODE_STOP_LIGHT;
      fall;
      `CHK(wake, 1'b1)
      stop_mode <= ufl_pkg::UFL_MODE_RUN;
      rd(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h04);
      stop_mode <= 2'h2;
      idle_cyc(2);
      stop_mode <= ufl_pkg::UFL_MODE_RUN;
      rd(ufl_pkg::UFL_OFS_CONTROL_TWO, 8'h00);
      rd(ufl_pkg::UFL_OFS_STATUS_TWO, 8'h00);
      $display("test edge and stop done");
   endtask : t_edge
   task automatic t_loop;
      wr(ufl_pkg::UFL_OFS_CONTROL_ONE, 8'h80);
      tx_ser <= 1'b0;
      idle_cyc(1);
      `CHK({rx_ser, rxd_rel}, 2'h1)
      wr(ufl_pkg::UFL_OFS_CONTROL_ONE, 8'hA0);
      tx_ser <= 1'b1;
      far_en <= 1'b1;
      far_lvl <= 1'b0;
      idle_cyc(1);
      `CHK({txd_oe, rx_ser, rxd_rel}, 3'h1)
      far_en <= 1'b0;
      wr(ufl_pkg::UFL_OFS_CONTROL_THREE, 8'h20);
      tx_ser <= 1'b0;
      idle_cyc(1);
      `CHK({txd_oe, txd_o, rx_ser}, 3'h4)
      $display("test loop done");
   endtask : t_loop
   // Main sequence
   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
      {tx_take, tx_idle, rx_valid, rx_char, rx_nf, rx_fe, rx_pf, rx_idle, rx_brk} = '0;
      {tx_ser, rxd, far_en, far_lvl} = 4'hD;
      stop_mode = ufl_pkg::UFL_MODE_RUN;
      reset = 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_rx;
      t_tx;
      t_edge;
      t_loop;
      end_sim;
   end
   // Watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      end_sim;
   end
endmodule : tb
